// ==== pls_local_io.sv ====
// Local I/O, interrupt inputs, run/stop selection and power-fail sequencing.
// ----------------------------------------------------------------
// Overview of operation
// - Local inputs 0 to 3 can each be enabled as interrupt sources.
// - Only rising edges of enabled interrupt inputs count as events.
// - A detected edge requests its routine at once, not at cycle boundaries.
// - An interrupt request immediately suspends the running program section.
// - Each output LED is lit exactly while its terminal is high; each input LED follows its terminal two clocks later.
// - Upper LED rows show the eight inputs, lower rows the six outputs.
// - Selector is sampled only at program cycle end, then that state entered.
// - Moving to Stop while running finishes the current cycle first.
// - Software mode requests act only as far as the selector allows.
// - Supply collapse switches off the 5 V supply to the I/O modules.
// - The warning signal starts an orderly power-down of the CPU.
// - Voltage drop starts data saving and cuts I/O 5 V to save energy.
// ----------------------------------------------------------------
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pls_local_io #(
	parameter int N_INPUTS  = 8,
	parameter int N_OUTPUTS = 6,
	parameter int N_IRQ     = 4
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 reset_i,
	input  wire logic [3:0]           bus_addr_i,
	input  wire logic [31:0]          bus_wdata_i,
	input  wire logic                 bus_wr_i,
	input  wire logic                 bus_rd_i,
	output logic      [31:0]          bus_rdata_o,
	input  wire logic [N_INPUTS-1:0]  local_input_i,
	input  wire logic                 run_stop_selector_i,
	input  wire logic                 supply_collapse_warning_i,
	output logic                      irq_o,
	output logic                      cpu_suspend_o,
	output logic      [N_IRQ-1:0]     irq_request_o,
	output logic      [N_OUTPUTS-1:0] local_output_o,
	output logic      [N_INPUTS-1:0]  led_input_row_o,
	output logic      [N_OUTPUTS-1:0] led_output_row_o,
	output logic                      run_o,
	output logic                      io_supply_enable_o,
	output logic                      data_save_req_o,
	output logic                      cpu_power_down_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (N_IRQ != 4 || N_INPUTS < N_IRQ || N_INPUTS > 8 || N_OUTPUTS > 8 || N_OUTPUTS < 1)
	begin : g_bad_params
		$error("pls_local_io: unsupported width parameters");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [N_INPUTS-1:0]  in_meta;
		logic [N_INPUTS-1:0]  in_sync;
		logic [N_INPUTS-1:0]  in_prev;
		logic                 sel_meta;
		logic                 sel_sync;
		logic                 pf_meta;
		logic                 pf_sync;
		logic [N_IRQ-1:0]     irq_en;
		logic [N_IRQ-1:0]     pending;
		logic [5:0]           status;
		logic [5:0]           mask;
		logic                 sw_run_req;
		pls_pkg::pls_mode_t   mode;
		pls_pkg::pls_pwr_t    pwr;
		logic [N_OUTPUTS-1:0] outputs;
		logic [31:0]          rdata;
	} pls_state_t;

	pls_state_t st;
	pls_state_t next_st;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [N_IRQ-1:0] edge_pulse;
		logic             cycle_end;
		logic             mode_before;
		logic [5:0]       set_bits;
		next_st = st;
		edge_pulse = '0;
		set_bits = '0;
		cycle_end = 1'b0;
		mode_before = 1'b0;

		// Two-stage synchronisers; the first stage feeds only the second.
		next_st.in_meta  = local_input_i;
		next_st.in_sync  = st.in_meta;
		next_st.in_prev  = st.in_sync;
		next_st.sel_meta = run_stop_selector_i;
		next_st.sel_sync = st.sel_meta;
		next_st.pf_meta  = supply_collapse_warning_i;
		next_st.pf_sync  = st.pf_meta;

		// Rising edge only, on enabled inputs 0 to 3.
		edge_pulse = st.in_sync[N_IRQ-1:0] & ~st.in_prev[N_IRQ-1:0] & st.irq_en;

		cycle_end = bus_wr_i && hit(bus_addr_i, pls_pkg::ADDR_CYCLE_END);
		mode_before = st.mode;

		// ----------------------------------------------------------------
		// Register writes
		// ----------------------------------------------------------------
		if (bus_wr_i)
		begin
			if (hit(bus_addr_i, pls_pkg::ADDR_MASK))
				next_st.mask = bus_wdata_i[5:0];
			if (hit(bus_addr_i, pls_pkg::ADDR_IRQ_EN))
				next_st.irq_en = bus_wdata_i[N_IRQ-1:0];
			if (hit(bus_addr_i, pls_pkg::ADDR_IRQ_ACK))
				next_st.pending = st.pending & ~bus_wdata_i[N_IRQ-1:0];
			if (hit(bus_addr_i, pls_pkg::ADDR_MODE_REQ))
				next_st.sw_run_req = bus_wdata_i[0];
			if (hit(bus_addr_i, pls_pkg::ADDR_OUTPUTS) && st.pwr == pls_pkg::PWR_NORMAL)
				next_st.outputs = bus_wdata_i[N_OUTPUTS-1:0];
		end
		// A new edge wins over an acknowledge in the same cycle.
		next_st.pending = next_st.pending | edge_pulse;

		// Mode changes happen at a cycle end, or at once to Stop on power failure; otherwise a running cycle completes.
		if (cycle_end)
		begin
			if (st.sel_sync && st.sw_run_req)
				next_st.mode = pls_pkg::MODE_RUN;
			else
				next_st.mode = pls_pkg::MODE_STOP;
		end

		// ----------------------------------------------------------------
		// Power-fail sequence
		// ----------------------------------------------------------------
		unique case (st.pwr)
			pls_pkg::PWR_NORMAL:
				if (st.pf_sync)
					next_st.pwr = pls_pkg::PWR_SAVING;
			pls_pkg::PWR_SAVING:
				// The warning may drop again; saving carries on regardless.
				if (bus_wr_i && hit(bus_addr_i, pls_pkg::ADDR_SAVE_DONE))
					next_st.pwr = pls_pkg::PWR_DOWN;
			pls_pkg::PWR_DOWN:
				next_st.pwr = pls_pkg::PWR_DOWN;
			default:
				next_st.pwr = pls_pkg::PWR_DOWN;
		endcase
		if (st.pwr != pls_pkg::PWR_NORMAL)
		begin
			next_st.mode = pls_pkg::MODE_STOP;
			next_st.outputs = pls_pkg::OUT_RESET[N_OUTPUTS-1:0];
		end

		// ----------------------------------------------------------------
		// Sticky status, cleared by reading it; a new event wins
		// ----------------------------------------------------------------
		set_bits[pls_pkg::STAT_EDGE_LSB +: 4] = edge_pulse;
		set_bits[pls_pkg::STAT_POWERFAIL] = st.pf_sync && st.pwr == pls_pkg::PWR_NORMAL;
		set_bits[pls_pkg::STAT_MODE_CHG] = (next_st.mode != mode_before);
		if (bus_rd_i && hit(bus_addr_i, pls_pkg::ADDR_STATUS))
			next_st.status = set_bits;
		else
			next_st.status = st.status | set_bits;

		// ----------------------------------------------------------------
		// Read data, valid in the cycle after the strobe only
		// ----------------------------------------------------------------
		next_st.rdata = '0;
		if (bus_rd_i)
		begin
			unique case (bus_addr_i)
				pls_pkg::ADDR_STATUS:   next_st.rdata = {26'h0, st.status};
				pls_pkg::ADDR_MASK:     next_st.rdata = {26'h0, st.mask};
				pls_pkg::ADDR_IRQ_EN:   next_st.rdata = {28'h0, st.irq_en};
				pls_pkg::ADDR_PENDING:  next_st.rdata = {28'h0, st.pending};
				pls_pkg::ADDR_MODE_REQ: next_st.rdata = {31'h0, st.sw_run_req};
				pls_pkg::ADDR_MODE:     next_st.rdata = {30'h0, st.sel_sync, st.mode};
				pls_pkg::ADDR_INPUTS:
					next_st.rdata = {{(32-N_INPUTS){1'b0}}, st.in_sync};
				pls_pkg::ADDR_OUTPUTS:
					next_st.rdata = {{(32-N_OUTPUTS){1'b0}}, st.outputs};
				pls_pkg::ADDR_POWER:    next_st.rdata = {30'h0, st.pwr};
				default:                next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			st            <= '0;
			st.irq_en     <= pls_pkg::IRQ_EN_RESET;
			st.mask       <= pls_pkg::MASK_RESET;
			st.mode       <= pls_pkg::MODE_STOP;
			st.pwr        <= pls_pkg::PWR_NORMAL;
			st.outputs    <= pls_pkg::OUT_RESET[N_OUTPUTS-1:0];
		end
		else
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rdata_o        = st.rdata;
	assign irq_o              = |(st.status & st.mask);
	assign irq_request_o      = st.pending;
	assign cpu_suspend_o      = |st.pending;
	assign local_output_o     = st.outputs;
	// LEDs follow the terminal levels: inputs on the upper rows, outputs on the lower.
	assign led_input_row_o    = st.in_sync;
	assign led_output_row_o   = st.outputs;
	assign run_o              = st.mode;
	assign io_supply_enable_o = (st.pwr == pls_pkg::PWR_NORMAL);
	assign data_save_req_o    = (st.pwr == pls_pkg::PWR_SAVING);
	assign cpu_power_down_o   = (st.pwr == pls_pkg::PWR_DOWN);

endmodule // pls_local_io

`default_nettype wire

// ==== pls_pkg.sv ====
// Package with the register map, status bits, reset values and mode and power-state types of the local I/O block.
package pls_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS    = 4'h0;
	localparam logic [3:0] ADDR_MASK      = 4'h1;
	localparam logic [3:0] ADDR_IRQ_EN    = 4'h2;
	localparam logic [3:0] ADDR_IRQ_ACK   = 4'h3;
	localparam logic [3:0] ADDR_PENDING   = 4'h4;
	localparam logic [3:0] ADDR_MODE_REQ  = 4'h5;
	localparam logic [3:0] ADDR_MODE      = 4'h6;
	localparam logic [3:0] ADDR_CYCLE_END = 4'h7;
	localparam logic [3:0] ADDR_INPUTS    = 4'h8;
	localparam logic [3:0] ADDR_OUTPUTS   = 4'h9;
	localparam logic [3:0] ADDR_POWER     = 4'ha;
	localparam logic [3:0] ADDR_SAVE_DONE = 4'hb;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int STAT_EDGE_LSB  = 0;
	localparam int STAT_POWERFAIL = 4;
	localparam int STAT_MODE_CHG  = 5;
	localparam int STAT_WIDTH     = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] MASK_RESET   = 6'h00;
	localparam logic [3:0] IRQ_EN_RESET = 4'h0;
	localparam logic [7:0] OUT_RESET    = 8'h00;

	// ----------------------------------------------------------------
	// Operating modes and power states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		MODE_STOP = 1'b0,
		MODE_RUN  = 1'b1
	} pls_mode_t;

	typedef enum logic [1:0] {
		PWR_NORMAL = 2'b00,
		PWR_SAVING = 2'b01,
		PWR_DOWN   = 2'b10
	} pls_pwr_t;

endpackage : pls_pkg

// ==== pls_local_io_asserts.sv ====
// Concurrent checks on the ports of the local I/O block.
`timescale 1ns/1ps
`default_nettype none
module pls_local_io_asserts #(
	parameter int N_INPUTS  = 8,
	parameter int N_OUTPUTS = 6,
	parameter int N_IRQ     = 4
) (
	input wire logic                 clk_sys_i,
	input wire logic                 reset_i,
	input wire logic [3:0]           bus_addr_i,
	input wire logic                 bus_wr_i,
	input wire logic [N_INPUTS-1:0]  local_input_i,
	input wire logic                 run_stop_selector_i,
	input wire logic                 supply_collapse_warning_i,
	input wire logic                 cpu_suspend_o,
	input wire logic [N_IRQ-1:0]     irq_request_o,
	input wire logic [N_OUTPUTS-1:0] local_output_o,
	input wire logic [N_INPUTS-1:0]  led_input_row_o,
	input wire logic [N_OUTPUTS-1:0] led_output_row_o,
	input wire logic                 run_o,
	input wire logic                 io_supply_enable_o,
	input wire logic                 data_save_req_o,
	input wire logic                 cpu_power_down_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_led_out_mirror: assert property (led_output_row_o == local_output_o)
		else $error("output LEDs differ from output terminals");
	// Three quiet cycles are needed so the input pipeline holds no reset values; the check waits four.
	a_led_in_mirror: assert property (!reset_i [*4] |-> led_input_row_o == $past(local_input_i, 2))
		else $error("input LEDs differ from delayed input terminals");
	a_save_cuts_io: assert property (data_save_req_o |-> !io_supply_enable_o)
		else $error("I/O supply on while saving");
	a_warn_starts_down: assert property (supply_collapse_warning_i [*4] |-> !io_supply_enable_o)
		else $error("I/O supply still on after warning");
	a_no_return: assert property (!io_supply_enable_o |=> !io_supply_enable_o)
		else $error("power-down sequence abandoned");
	a_down_sticky: assert property (cpu_power_down_o |=> cpu_power_down_o)
		else $error("power-down state left");
	a_suspend_follows: assert property (|irq_request_o |-> ##[0:1] cpu_suspend_o)
		else $error("pending request without suspend");
	a_edge_only_rise: assert property ($rose(irq_request_o[0]) |->
		$past(local_input_i[0], 2) || $past(local_input_i[0], 3) || $past(local_input_i[0], 4))
		else $error("request without a rising input");
	a_mode_at_end: assert property (!$past(reset_i) && $changed(run_o) |->
		$past(bus_wr_i && bus_addr_i == pls_pkg::ADDR_CYCLE_END) || !io_supply_enable_o)
		else $error("mode changed outside cycle end");
	a_switch_wins: assert property ($rose(run_o) |-> $past(run_stop_selector_i, 3))
		else $error("run entered with selector at stop");
	c_request: cover property ($rose(irq_request_o[0]));
	c_run: cover property ($rose(run_o));
	c_power_down: cover property ($rose(cpu_power_down_o));
endmodule // pls_local_io_asserts
bind pls_local_io pls_local_io_asserts #(.N_INPUTS(N_INPUTS), .N_OUTPUTS(N_OUTPUTS), .N_IRQ(N_IRQ))
	u_chk (.clk_sys_i, .reset_i, .bus_addr_i, .bus_wr_i, .local_input_i, .run_stop_selector_i,
	.supply_collapse_warning_i, .cpu_suspend_o, .irq_request_o, .local_output_o, .led_input_row_o,
	.led_output_row_o, .run_o, .io_supply_enable_o, .data_save_req_o, .cpu_power_down_o);
`default_nettype wire

// ==== pls_field_model.sv ====
// Field side: input terminals, mode selector and supply monitor.
`timescale 1ns/1ps
`default_nettype none
module pls_field_model (
	input wire logic        clk_sys_i,
	input wire logic [7:0]  in_req_i,
	input wire logic        sel_req_i,
	input wire logic        warn_req_i,
	output var logic [7:0]  local_input_o = 8'h00,
	output var logic        run_stop_selector_o = 1'b0,
	output var logic        supply_collapse_warning_o = 1'b0
);
	// Lines move just after an edge, like contacts that settle between samples.
	always @(posedge clk_sys_i)
	begin
		local_input_o <= in_req_i;
		run_stop_selector_o <= sel_req_i;
		supply_collapse_warning_o <= warn_req_i;
	end
endmodule // pls_field_model
`default_nettype wire

// ==== pls_local_io_tb.sv ====
// Self-checking testbench of the local I/O block.
`timescale 1ns/1ps
`default_nettype none
module pls_local_io_tb;
	logic        clk_sys_i = 1'b0, reset_i = 1'b1, bus_wr_i = 1'b0, bus_rd_i = 1'b0, rd_d = 1'b0;
	logic [3:0]  bus_addr_i = 4'h0;
	logic [31:0] bus_wdata_i = 32'h0, bus_rdata_o, r;
	logic [7:0]  in_req = 8'h00, local_input_i, led_input_row_o;
	logic        sel_req = 1'b0, warn_req = 1'b0, run_stop_selector_i, supply_collapse_warning_i;
	logic        irq_o, cpu_suspend_o, run_o, io_supply_enable_o, data_save_req_o, cpu_power_down_o;
	logic [3:0]  irq_request_o;
	logic [5:0]  local_output_o, led_output_row_o;
	int          fails = 0, compares = 0, cyc = 0;
	logic [31:0] q[$];
	always #2 clk_sys_i = ~clk_sys_i;
	pls_field_model i_pls_field_model (.clk_sys_i, .in_req_i(in_req), .sel_req_i(sel_req),
		.warn_req_i(warn_req), .local_input_o(local_input_i),
		.run_stop_selector_o(run_stop_selector_i), .supply_collapse_warning_o(supply_collapse_warning_i));
	pls_local_io i_pls_local_io (.clk_sys_i, .reset_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i,
		.bus_rd_i, .bus_rdata_o, .local_input_i, .run_stop_selector_i, .supply_collapse_warning_i,
		.irq_o, .cpu_suspend_o, .irq_request_o, .local_output_o, .led_input_row_o,
		.led_output_row_o, .run_o, .io_supply_enable_o, .data_save_req_o, .cpu_power_down_o);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
			fails++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus_addr_i <= a;
		bus_wdata_i <= d;
		bus_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		bus_wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		bus_addr_i <= a;
		bus_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		bus_rd_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task wrap_up;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken at that edge.
	always @(posedge clk_sys_i)
	begin
		if (rd_d)
			chk(bus_rdata_o, q.pop_front());
		rd_d <= bus_rd_i;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			wrap_up();
		end
	end
	initial
	begin
		void'($urandom(32'h05c1));
		wait_n(10);
		reset_i <= 1'b0;
		wait_n(1);
		chk(io_supply_enable_o, 1'b1);
		rd(pls_pkg::ADDR_PENDING, 32'h0);
		wr(pls_pkg::ADDR_IRQ_EN, 32'h7);
		wr(pls_pkg::ADDR_MASK, 32'h3f);
		in_req <= 8'h0d;
		wait_n(8);
		rd(pls_pkg::ADDR_PENDING, 32'h5);
		chk(irq_request_o, 4'h5);
		chk(cpu_suspend_o, 1'b1);
		chk(irq_o, 1'b1);
		wr(pls_pkg::ADDR_IRQ_ACK, 32'h5);
		in_req <= 8'h00;
		wait_n(8);
		rd(pls_pkg::ADDR_PENDING, 32'h0);
		chk(cpu_suspend_o, 1'b0);
		wr(pls_pkg::ADDR_MASK, 32'h0);
		wait_n(2);
		chk(irq_o, 1'b0);
		wr(pls_pkg::ADDR_MASK, 32'h3f);
		wait_n(2);
		chk(irq_o, 1'b1);
		rd(pls_pkg::ADDR_STATUS, 32'h5);
		rd(pls_pkg::ADDR_STATUS, 32'h0);
		wait_n(2);
		chk(irq_o, 1'b0);
		r = $urandom;
		in_req <= r[7:0];
		wait_n(6);
		chk(led_input_row_o, r[7:0]);
		rd(pls_pkg::ADDR_INPUTS, {24'h0, r[7:0]});
		wr(pls_pkg::ADDR_OUTPUTS, {26'h0, r[13:8]});
		wait_n(2);
		chk(led_output_row_o, r[13:8]);
		chk(local_output_o, r[13:8]);
		for (int i = 0; i < 4; i++)
		begin
			sel_req <= i[1];
			wr(pls_pkg::ADDR_MODE_REQ, i);
			wait_n(6);
			chk(run_o, 1'b0);
			wr(pls_pkg::ADDR_CYCLE_END, 32'h0);
			wait_n(2);
			chk(run_o, i == 3);
		end
		sel_req <= 1'b0;
		wait_n(6);
		chk(run_o, 1'b1);
		wr(pls_pkg::ADDR_CYCLE_END, 32'h0);
		wait_n(2);
		chk(run_o, 1'b0);
		warn_req <= 1'b1;
		wait_n(8);
		chk(io_supply_enable_o, 1'b0);
		chk(data_save_req_o, 1'b1);
		chk(local_output_o, 32'h0);
		wr(pls_pkg::ADDR_OUTPUTS, 32'h3f);
		wait_n(2);
		chk(local_output_o, 32'h0);
		warn_req <= 1'b0;
		wait_n(6);
		chk(io_supply_enable_o, 1'b0);
		wr(pls_pkg::ADDR_SAVE_DONE, 32'h0);
		wait_n(2);
		chk(cpu_power_down_o, 1'b1);
		rd(pls_pkg::ADDR_POWER, 32'h2);
		wrap_up();
	end
endmodule // pls_local_io_tb
`default_nettype wire
